// >>> crfs_dp_model.sv
// Partner model: the execution datapath issuing sized register accesses.
// Assumes the register file answers a read one cycle after the request.
`timescale 1ns/10ps
module crfs_dp_model
   import crfs_pkg::*;
(
   // Clock
   input wire logic clk,
   // Requests toward the register file
   output crfs_req_t rd_req,
   output logic rd_valid,
   output crfs_req_t wr_req,
   output logic wr_valid,
   output logic [31:0] wr_data,
   // Answers from the register file
   input wire logic rd_valid_q,
   input wire logic [31:0] rd_data_q,
   input wire logic wr_err_q
);
   // Idle request lines
   initial begin
      rd_valid = 1'b0;
      wr_valid = 1'b0;
      rd_req = '{CRFS_K_NONE, 3'h0, CRFS_SZ_BYTE, 1'b0};
      wr_req = '{CRFS_K_NONE, 3'h0, CRFS_SZ_BYTE, 1'b0};
      wr_data = 32'h5A5A_A5A5;
   end

   // One sized write; data lines carry the inverse once released
   task automatic wr(input crfs_kind_t k, input logic [2:0] i,
                     input crfs_size_t s, input logic [31:0] d,
                     output logic err);
      @(posedge clk);
      wr_req <= '{k, i, s, 1'b0};
      wr_data <= d;
      wr_valid <= 1'b1;
      @(posedge clk);
      wr_valid <= 1'b0;
      wr_data <= ~d;
      #1;
      err = wr_err_q;
   endtask : wr

   // One sized read; result is taken one cycle after the request
   task automatic rd(input crfs_kind_t k, input logic [2:0] i,
                     input crfs_size_t s, input logic x,
                     output logic [31:0] d, output logic v);
      @(posedge clk);
      rd_req <= '{k, i, s, x};
      rd_valid <= 1'b1;
      @(posedge clk);
      rd_valid <= 1'b0;
      #1;
      d = rd_data_q;
      v = rd_valid_q;
   endtask : rd
endmodule : crfs_dp_model

// >>> crfs_pkg.sv
// Constants, types and carriers shared by the operand-sized register file.
// Assumes one processor clock; nothing here holds state.
package crfs_pkg;

   // Operand widths
   localparam int unsigned CRFS_BYTE_W = 8;
   localparam int unsigned CRFS_WORD_W = 16;
   localparam int unsigned CRFS_LONG_W = 32;
   localparam int unsigned CRFS_CODE_W = 3;

   // Register counts: data registers and address slots (slot 7 = user stack)
   localparam int unsigned CRFS_N_DATA = 8;
   localparam int unsigned CRFS_N_ADDR = 8;

   // Bus byte offsets
   localparam logic [7:0] CRFS_OFS_DATA = 8'h00;
   localparam logic [7:0] CRFS_OFS_ADDR = 8'h20;
   localparam logic [7:0] CRFS_OFS_CTRL = 8'h40;
   localparam logic [7:0] CRFS_OFS_LAST = 8'h58;

   // Control register selectors (also word index inside the control block)
   localparam logic [2:0] CRFS_CTL_SW = 3'h0;
   localparam logic [2:0] CRFS_CTL_FLAGS = 3'h1;
   localparam logic [2:0] CRFS_CTL_BASE = 3'h2;
   localparam logic [2:0] CRFS_CTL_SRC_CODE = 3'h3;
   localparam logic [2:0] CRFS_CTL_DST_CODE = 3'h4;
   localparam logic [2:0] CRFS_CTL_USP = 3'h5;
   localparam logic [2:0] CRFS_CTL_SSP = 3'h6;

   // Status word layout: defined bits, supervisor bit, stack slot
   localparam logic [15:0] CRFS_SW_MASK = 16'hA71F;
   localparam logic [7:0] CRFS_FLAGS_MASK = 8'h1F;
   localparam int unsigned CRFS_SUPER_BIT = 13;
   localparam logic [2:0] CRFS_SP_SLOT = 3'h7;

   // Reset values
   localparam logic [31:0] CRFS_RST_REG = 32'h0000_0000;
   localparam logic [15:0] CRFS_RST_SW = 16'h2700;
   localparam logic [2:0] CRFS_RST_CODE = 3'h0;

   // Operand size and register class
   typedef enum logic [1:0] {
      CRFS_SZ_BYTE = 2'b00,
      CRFS_SZ_WORD = 2'b01,
      CRFS_SZ_LONG = 2'b10,
      CRFS_SZ_BAD = 2'b11
   } crfs_size_t;

   typedef enum logic [1:0] {
      CRFS_K_DATA = 2'b00,
      CRFS_K_ADDR = 2'b01,
      CRFS_K_CTRL = 2'b10,
      CRFS_K_NONE = 2'b11
   } crfs_kind_t;

   // One register access from the datapath
   typedef struct packed {
      crfs_kind_t kind;
      logic [2:0] idx;
      crfs_size_t size;
      logic addr_dst;
   } crfs_req_t;

endpackage : crfs_pkg

// >>> crfs_regfile.sv
// Operand-sized register file: data, address, stack and control registers,
// reached by the execution datapath and by an APB slave.
// Assumes one clock; datapath requests are synchronous to clk.
`timescale 1ns/10ps
module crfs_regfile
   import crfs_pkg::*;
(
   // Clock and reset
   input wire logic clk,
   input wire logic reset,
   // Datapath read port
   input wire logic rd_valid,
   input wire crfs_req_t rd_req,
   output logic rd_valid_q,
   output logic [31:0] rd_data_q,
   // Datapath write port
   input wire logic wr_valid,
   input wire crfs_req_t wr_req,
   input wire logic [31:0] wr_data,
   output logic wr_err_q,
   // Status view
   output logic [15:0] status_q,
   // APB slave
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr
);

   // Register storage
   logic [31:0] data_q [CRFS_N_DATA];
   logic [31:0] data_d [CRFS_N_DATA];
   logic [31:0] ar_q [CRFS_N_ADDR];
   logic [31:0] ar_d [CRFS_N_ADDR];
   logic [31:0] ssp_q;
   logic [31:0] ssp_d;
   logic [15:0] sw_q;
   logic [15:0] sw_d;
   logic [31:0] tbase_q;
   logic [31:0] tbase_d;
   logic [CRFS_CODE_W-1:0] src_code_q;
   logic [CRFS_CODE_W-1:0] src_code_d;
   logic [CRFS_CODE_W-1:0] dst_code_q;
   logic [CRFS_CODE_W-1:0] dst_code_d;
   logic rd_valid_d;
   logic [31:0] rd_data_d;
   logic wr_err_d;
   logic pready_q;
   logic pready_d;
   logic pslverr_q;
   logic pslverr_d;
   logic [31:0] prdata_q;
   logic [31:0] prdata_d;

   // Register value before size shaping
   function automatic logic [31:0] raw_sel(input crfs_kind_t k,
                                           input logic [2:0] i);
      logic [31:0] v;
      v = CRFS_RST_REG;
      case (k)
         CRFS_K_DATA: v = data_q[i];
         CRFS_K_ADDR: begin
            if (i == CRFS_SP_SLOT && sw_q[CRFS_SUPER_BIT]) v = ssp_q;
            else v = ar_q[i];
         end
         CRFS_K_CTRL: begin
            case (i)
               CRFS_CTL_SW: v = {16'h0000, sw_q & CRFS_SW_MASK};
               CRFS_CTL_FLAGS:
                  v = {24'h000000, sw_q[7:0] & CRFS_FLAGS_MASK};
               CRFS_CTL_BASE: v = tbase_q;
               CRFS_CTL_SRC_CODE: v = {29'h00000000, src_code_q};
               CRFS_CTL_DST_CODE: v = {29'h00000000, dst_code_q};
               CRFS_CTL_USP: v = ar_q[CRFS_SP_SLOT];
               CRFS_CTL_SSP: v = ssp_q;
               default: v = CRFS_RST_REG;
            endcase
         end
         default: v = CRFS_RST_REG;
      endcase
      return v;
   endfunction : raw_sel

   // Low-order portion of a data or address source, zero or sign extended; control registers whole
   function automatic logic [31:0] shape(input logic [31:0] v,
                                         input crfs_req_t r);
      logic [31:0] s;
      s = v;
      if (r.kind == CRFS_K_CTRL) s = v;
      else if (r.size == CRFS_SZ_BYTE) s = {24'h000000, v[7:0]};
      else if (r.size == CRFS_SZ_WORD) begin
         if (r.addr_dst) s = {{16{v[15]}}, v[15:0]};
         else s = {16'h0000, v[15:0]};
      end
      return s;
   endfunction : shape

   // Merge a sized result into the old data register value
   function automatic logic [31:0] merge(input logic [31:0] old_v,
                                         input logic [31:0] new_v,
                                         input crfs_size_t sz);
      logic [31:0] m;
      m = old_v;
      case (sz)
         CRFS_SZ_BYTE: m = {old_v[31:8], new_v[7:0]};
         CRFS_SZ_WORD: m = {old_v[31:16], new_v[15:0]};
         CRFS_SZ_LONG: m = new_v;
         default: m = old_v;
      endcase
      return m;
   endfunction : merge

   // APB decode: word aligned, inside the map
   wire apb_access = psel & penable;
   wire apb_mapped = (paddr <= CRFS_OFS_LAST) & (paddr[1:0] == 2'b00);
   wire crfs_kind_t apb_kind = crfs_kind_t'(paddr[6:5]);
   wire [2:0] apb_idx = paddr[4:2];
   wire apb_wr = apb_access & pready_q & pwrite & apb_mapped;
   wire crfs_req_t apb_req = '{kind: apb_kind, idx: apb_idx,
                               size: CRFS_SZ_LONG, addr_dst: 1'b0};

   // Write arbitration: the datapath wins a shared cycle
   wire dp_bad = (wr_req.size == CRFS_SZ_BAD) |
                 (wr_req.kind == CRFS_K_NONE) |
                 (wr_req.kind == CRFS_K_ADDR &&
                  wr_req.size == CRFS_SZ_BYTE);
   wire dp_wr = wr_valid & ~dp_bad;
   wire w_en = dp_wr | (apb_wr & ~wr_valid);
   wire crfs_req_t w_req = dp_wr ? wr_req : apb_req;
   wire [31:0] w_data = dp_wr ? wr_data : pwdata;
   wire w_data_hit = w_en & (w_req.kind == CRFS_K_DATA);
   wire w_addr_hit = w_en & (w_req.kind == CRFS_K_ADDR);
   wire w_ctrl_hit = w_en & (w_req.kind == CRFS_K_CTRL);
   wire super_mode = sw_q[CRFS_SUPER_BIT];

   // Address destination value: whole register, word sign-extended
   wire [31:0] w_addr_val = (w_req.size == CRFS_SZ_WORD) ?
                            {{16{w_data[15]}}, w_data[15:0]} :
                            w_data;

   // Data registers: sized merge per register
   genvar g;
   generate
      for (g = 0; g < CRFS_N_DATA; g = g + 1) begin : g_data
         assign data_d[g] = (w_data_hit && w_req.idx == 3'(g)) ?
                            merge(data_q[g], w_data, w_req.size) :
                            data_q[g];
      end
   endgenerate

   // Address slots; slot 7 is the user stack pointer
   generate
      for (g = 0; g < CRFS_N_ADDR; g = g + 1) begin : g_addr
         wire dir_hit = w_addr_hit && w_req.idx == 3'(g) &&
                        !(g == CRFS_SP_SLOT && super_mode);
         wire usp_hit = (g == CRFS_SP_SLOT) && w_ctrl_hit &&
                        w_req.idx == CRFS_CTL_USP;
         assign ar_d[g] = dir_hit ? w_addr_val :
                          usp_hit ? w_data : ar_q[g];
      end
   endgenerate

   // Supervisor stack pointer: slot 7 in supervisor mode or by selector
   wire ssp_dir = w_addr_hit & (w_req.idx == CRFS_SP_SLOT) & super_mode;
   wire ssp_ctl = w_ctrl_hit & (w_req.idx == CRFS_CTL_SSP);
   assign ssp_d = ssp_dir ? w_addr_val : ssp_ctl ? w_data : ssp_q;

   // Status word and condition byte; undefined bits never stored
   wire sw_hit = w_ctrl_hit & (w_req.idx == CRFS_CTL_SW);
   wire flags_hit = w_ctrl_hit & (w_req.idx == CRFS_CTL_FLAGS);
   assign sw_d = sw_hit ? (w_data[15:0] & CRFS_SW_MASK) :
                 flags_hit ? {sw_q[15:8],
                              w_data[7:0] & CRFS_FLAGS_MASK} :
                 sw_q;

   // Table base takes the whole long whatever size was asked
   wire tbase_hit = w_ctrl_hit & (w_req.idx == CRFS_CTL_BASE);
   assign tbase_d = tbase_hit ? w_data : tbase_q;

   // Alternate space codes keep three bits only
   wire src_code_hit = w_ctrl_hit & (w_req.idx == CRFS_CTL_SRC_CODE);
   wire dst_code_hit = w_ctrl_hit & (w_req.idx == CRFS_CTL_DST_CODE);
   assign src_code_d = src_code_hit ? w_data[CRFS_CODE_W-1:0] :
                       src_code_q;
   assign dst_code_d = dst_code_hit ? w_data[CRFS_CODE_W-1:0] :
                       dst_code_q;

   // Datapath read answer one cycle after the request
   assign rd_valid_d = rd_valid;
   assign rd_data_d = rd_valid ? shape(raw_sel(rd_req.kind, rd_req.idx),
                                       rd_req) : rd_data_q;
   assign wr_err_d = wr_valid & dp_bad;

   // APB: one wait state, then a single-cycle ready
   assign pready_d = apb_access & ~pready_q;
   assign pslverr_d = apb_access & ~pready_q & ~apb_mapped;
   assign prdata_d = (apb_access & ~pready_q & ~pwrite & apb_mapped) ?
                     raw_sel(apb_kind, apb_idx) : 32'h0000_0000;

   // Register array update
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         for (int i = 0; i < CRFS_N_DATA; i++) data_q[i] <= CRFS_RST_REG;
         for (int i = 0; i < CRFS_N_ADDR; i++) ar_q[i] <= CRFS_RST_REG;
      end else begin
         for (int i = 0; i < CRFS_N_DATA; i++) data_q[i] <= data_d[i];
         for (int i = 0; i < CRFS_N_ADDR; i++) ar_q[i] <= ar_d[i];
      end
   end

   // Control registers
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         ssp_q <= CRFS_RST_REG;
         sw_q <= CRFS_RST_SW;
         tbase_q <= CRFS_RST_REG;
         src_code_q <= CRFS_RST_CODE;
         dst_code_q <= CRFS_RST_CODE;
      end else begin
         ssp_q <= ssp_d;
         sw_q <= sw_d;
         tbase_q <= tbase_d;
         src_code_q <= src_code_d;
         dst_code_q <= dst_code_d;
      end
   end

   // Answer flops
   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         rd_valid_q <= 1'b0;
         rd_data_q <= CRFS_RST_REG;
         wr_err_q <= 1'b0;
         pready_q <= 1'b0;
         pslverr_q <= 1'b0;
         prdata_q <= CRFS_RST_REG;
      end else begin
         rd_valid_q <= rd_valid_d;
         rd_data_q <= rd_data_d;
         wr_err_q <= wr_err_d;
         pready_q <= pready_d;
         pslverr_q <= pslverr_d;
         prdata_q <= prdata_d;
      end
   end

   // Output drive
   assign pready = pready_q;
   assign pslverr = pslverr_q;
   assign prdata = prdata_q;
   assign status_q = sw_q;

   // Byte write to a data register leaves bits 31..8 alone
   a_byte_keeps_upper:
   assert property (@(posedge clk) disable iff (reset)
      (dp_wr && wr_req.kind == CRFS_K_DATA && wr_req.size == CRFS_SZ_BYTE
       && wr_req.idx == 3'h0)
      |=> (data_q[0][31:8] == $past(data_q[0][31:8])) &&
          (data_q[0][7:0] == $past(wr_data[7:0])))
      else $error("byte write disturbed data register upper bits");

   // Word write to a data register keeps bits 31..16
   a_word_keeps_upper:
   assert property (@(posedge clk) disable iff (reset)
      (dp_wr && wr_req.kind == CRFS_K_DATA && wr_req.size == CRFS_SZ_WORD
       && wr_req.idx == 3'h3)
      |=> data_q[3] == {$past(data_q[3][31:16]), $past(wr_data[15:0])})
      else $error("word write to data register wrong");

   // Word write to an address register is sign-extended over 32 bits
   a_addr_word_sext:
   assert property (@(posedge clk) disable iff (reset)
      (dp_wr && wr_req.kind == CRFS_K_ADDR && wr_req.size == CRFS_SZ_WORD
       && wr_req.idx == 3'h2)
      |=> ar_q[2] == {{16{$past(wr_data[15])}}, $past(wr_data[15:0])})
      else $error("address word write not sign extended");

   // Byte size to an address register is refused and flagged
   a_addr_byte_refused:
   assert property (@(posedge clk) disable iff (reset)
      (wr_valid && wr_req.kind == CRFS_K_ADDR &&
       wr_req.size == CRFS_SZ_BYTE && wr_req.idx == 3'h2)
      |=> wr_err_q && $stable(ar_q[2]))
      else $error("byte write to address register not refused");

   // Undefined status bits never hold a one
   a_status_undef_zero:
   assert property (@(posedge clk) disable iff (reset)
      (sw_q & ~CRFS_SW_MASK) == 16'h0000)
      else $error("undefined status bit set");

   // Condition byte write leaves the upper status byte unchanged
   a_flags_upper_kept:
   assert property (@(posedge clk) disable iff (reset)
      flags_hit |=> (sw_q[15:8] == $past(sw_q[15:8])) &&
                  (sw_q[7:0] == ($past(w_data[7:0]) & CRFS_FLAGS_MASK)))
      else $error("condition byte write touched system byte");

   // Byte read of a data register returns zero upper bits
   a_read_byte_zext:
   assert property (@(posedge clk) disable iff (reset)
      (rd_valid && rd_req.kind == CRFS_K_DATA &&
       rd_req.size == CRFS_SZ_BYTE)
      |=> rd_valid_q && rd_data_q[31:8] == 24'h000000)
      else $error("byte read leaked upper bits");

   // Table base written whole even for a word-sized request
   a_tbase_long_only:
   assert property (@(posedge clk) disable iff (reset)
      tbase_hit |=> tbase_q == $past(w_data))
      else $error("table base not written as long word");

   // Space code reads show zero above bit 2
   a_code_read_zero:
   assert property (@(posedge clk) disable iff (reset)
      (rd_valid && rd_req.kind == CRFS_K_CTRL &&
       rd_req.idx == CRFS_CTL_SRC_CODE)
      |=> rd_data_q[31:3] == 29'h00000000 &&
          rd_data_q[2:0] == $past(src_code_q))
      else $error("space code read shows upper bits");

   // APB ready is one pulse, two cycles into the transfer
   a_apb_ready_pulse:
   assert property (@(posedge clk) disable iff (reset)
      ($rose(psel) && !penable) ##1 penable |=> pready ##1 !pready)
      else $error("APB ready timing wrong");

endmodule : crfs_regfile

// >>> test_crfs_regfile.sv
// Testbench for the operand-sized register file.
// Assumes the datapath partner model and an APB master task in this bench.
`timescale 1ns/10ps
module test_crfs_regfile
   import crfs_pkg::*;
;
   logic clk, reset, rd_valid, rd_valid_q, wr_valid, wr_err_q;
   crfs_req_t rd_req, wr_req;
   logic [31:0] rd_data_q, wr_data, pwdata, prdata;
   logic [15:0] status_q;
   logic [7:0] paddr;
   logic psel, penable, pwrite, pready, pslverr;
   int failures = 0;
   int samples_checked = 0;

   // Design and partner
   crfs_regfile crfs_regfile_i (.clk(clk), .reset(reset),
      .rd_valid(rd_valid), .rd_req(rd_req), .rd_valid_q(rd_valid_q),
      .rd_data_q(rd_data_q), .wr_valid(wr_valid), .wr_req(wr_req),
      .wr_data(wr_data), .wr_err_q(wr_err_q), .status_q(status_q),
      .paddr(paddr), .psel(psel), .penable(penable), .pwrite(pwrite),
      .pwdata(pwdata), .prdata(prdata), .pready(pready),
      .pslverr(pslverr));
   crfs_dp_model crfs_dp_model_i (.clk(clk), .rd_req(rd_req),
      .rd_valid(rd_valid), .wr_req(wr_req), .wr_valid(wr_valid),
      .wr_data(wr_data), .rd_valid_q(rd_valid_q), .rd_data_q(rd_data_q),
      .wr_err_q(wr_err_q));

   // Verdict and end of run
   task automatic results();
      $display("checked %0d failures %0d", samples_checked, failures);
      if (failures == 0 && samples_checked > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : results

   // Compare one 32-bit value
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      samples_checked++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // APB transfer with bounded wait for pready
   task automatic apb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, input logic [31:0] er,
                      input logic ee);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      for (n = 0; n < 16; n++) begin
         @(posedge clk);
         if (pready === 1'b1) break;
      end
      if (n == 16) begin
         failures++;
         results();
      end
      if (!w) chk(prdata, er);
      chk({31'h0, pslverr}, {31'h0, ee});
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb

   // Datapath write, checking the refusal flag
   task automatic dw(input crfs_kind_t k, input logic [2:0] i,
                     input crfs_size_t s, input logic [31:0] d,
                     input logic ee);
      logic e;
      crfs_dp_model_i.wr(k, i, s, d, e);
      chk({31'h0, e}, {31'h0, ee});
   endtask : dw

   // Datapath read, checking valid pulse and value
   task automatic dr(input crfs_kind_t k, input logic [2:0] i,
                     input crfs_size_t s, input logic x,
                     input logic [31:0] exp);
      logic [31:0] d;
      logic v;
      crfs_dp_model_i.rd(k, i, s, x, d, v);
      chk({31'h0, v}, 32'h1);
      chk(d, exp);
   endtask : dr

   // Values after reset
   task automatic t_reset();
      chk({16'h0, status_q}, {16'h0, CRFS_RST_SW});
      apb(1'b0, 8'h40, 32'h0, {16'h0, CRFS_RST_SW}, 1'b0);
      dr(CRFS_K_DATA, 3'h0, CRFS_SZ_LONG, 1'b0, 32'h0);
      $display("test reset done");
   endtask : t_reset

   // Partial-width writes and reads of a data register
   task automatic t_data();
      dw(CRFS_K_DATA, 3'h0, CRFS_SZ_BYTE, 32'h1234_565A, 1'b0);
      dr(CRFS_K_DATA, 3'h0, CRFS_SZ_LONG, 1'b0, 32'h0000_005A);
      dw(CRFS_K_DATA, 3'h3, CRFS_SZ_LONG, 32'h1122_3344, 1'b0);
      dw(CRFS_K_DATA, 3'h3, CRFS_SZ_BYTE, 32'hFFFF_FFA5, 1'b0);
      dr(CRFS_K_DATA, 3'h3, CRFS_SZ_LONG, 1'b0, 32'h1122_33A5);
      dw(CRFS_K_DATA, 3'h3, CRFS_SZ_WORD, 32'hFFFF_BEEF, 1'b0);
      dr(CRFS_K_DATA, 3'h3, CRFS_SZ_BYTE, 1'b0, 32'h0000_00EF);
      dr(CRFS_K_DATA, 3'h3, CRFS_SZ_WORD, 1'b0, 32'h0000_BEEF);
      apb(1'b0, 8'h0C, 32'h0, 32'h1122_BEEF, 1'b0);
      apb(1'b1, 8'h1C, 32'h8000_0001, 32'h0, 1'b0);
      dr(CRFS_K_DATA, 3'h7, CRFS_SZ_LONG, 1'b0, 32'h8000_0001);
      $display("test data done");
   endtask : t_data

   // Address register sizing and sign extension
   task automatic t_addr();
      dw(CRFS_K_ADDR, 3'h2, CRFS_SZ_WORD, 32'h1234_8001, 1'b0);
      dr(CRFS_K_ADDR, 3'h2, CRFS_SZ_LONG, 1'b0, 32'hFFFF_8001);
      dr(CRFS_K_ADDR, 3'h2, CRFS_SZ_WORD, 1'b1, 32'hFFFF_8001);
      dr(CRFS_K_ADDR, 3'h2, CRFS_SZ_WORD, 1'b0, 32'h0000_8001);
      dw(CRFS_K_ADDR, 3'h2, CRFS_SZ_BYTE, 32'h0000_0055, 1'b1);
      apb(1'b0, 8'h28, 32'h0, 32'hFFFF_8001, 1'b0);
      dw(CRFS_K_ADDR, 3'h7, CRFS_SZ_LONG, 32'h0000_1000, 1'b0);
      apb(1'b0, 8'h58, 32'h0, 32'h0000_1000, 1'b0);
      apb(1'b1, 8'h54, 32'h0000_2000, 32'h0, 1'b0);
      dr(CRFS_K_ADDR, 3'h7, CRFS_SZ_LONG, 1'b0, 32'h0000_1000);
      dw(CRFS_K_CTRL, CRFS_CTL_SW, CRFS_SZ_LONG, 32'h0, 1'b0);
      chk({16'h0, status_q}, 32'h0);
      dr(CRFS_K_ADDR, 3'h7, CRFS_SZ_LONG, 1'b0, 32'h0000_2000);
      $display("test addr done");
   endtask : t_addr

   // Control registers and their masks
   task automatic t_ctrl();
      dw(CRFS_K_CTRL, CRFS_CTL_SW, CRFS_SZ_LONG, '1, 1'b0);
      chk({16'h0, status_q}, {16'h0, CRFS_SW_MASK});
      dw(CRFS_K_CTRL, CRFS_CTL_FLAGS, CRFS_SZ_WORD, 32'hFFEA, 1'b0);
      dr(CRFS_K_CTRL, CRFS_CTL_FLAGS, CRFS_SZ_WORD, 1'b0, 32'hA);
      apb(1'b0, 8'h40, 32'h0, 32'h0000_A70A, 1'b0);
      dw(CRFS_K_CTRL, CRFS_CTL_BASE, CRFS_SZ_WORD, 32'hDEAD_BEEF,
         1'b0);
      dr(CRFS_K_CTRL, CRFS_CTL_BASE, CRFS_SZ_BYTE, 1'b0,
         32'hDEAD_BEEF);
      dw(CRFS_K_CTRL, CRFS_CTL_SRC_CODE, CRFS_SZ_LONG, '1, 1'b0);
      dr(CRFS_K_CTRL, CRFS_CTL_SRC_CODE, CRFS_SZ_LONG, 1'b0, 32'h7);
      apb(1'b1, 8'h50, 32'hFFFF_FFFA, 32'h0, 1'b0);
      apb(1'b0, 8'h50, 32'h0, 32'h0000_0002, 1'b0);
      $display("test ctrl done");
   endtask : t_ctrl

   // Refused accesses on both ports
   task automatic t_err();
      apb(1'b0, 8'h5C, 32'h0, 32'h0, 1'b1);
      apb(1'b1, 8'h02, 32'hFFFF_FFFF, 32'h0, 1'b1);
      dw(CRFS_K_DATA, 3'h0, CRFS_SZ_BAD, 32'hFFFF_FFFF, 1'b1);
      dw(CRFS_K_NONE, 3'h0, CRFS_SZ_LONG, 32'hFFFF_FFFF, 1'b1);
      dr(CRFS_K_DATA, 3'h0, CRFS_SZ_LONG, 1'b0, 32'h0000_005A);
      $display("test err done");
   endtask : t_err

   // Clock
   initial begin
      clk = 1'b0;
      forever #5 clk = ~clk;
   end

   // Reset, then the scenarios
   initial begin
      reset = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 8'h00;
      pwdata = 32'h0;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      t_reset();
      t_data();
      t_addr();
      t_ctrl();
      t_err();
      results();
   end
endmodule : test_crfs_regfile
